// [rtl/seq_pkg.sv]
// Constants and types shared by the regulator start-up and fault sequencer.
//
// Behaviour
// (R01) Soft-start begins 384 cycles after enable, bias supplies and clock lock.
// (R02) Enable hysteresis current sink is on until the system is enabled.
// (R03) Shutdown, fault or supply loss resets soft-start and gates at once.
// (R04) Soft-start counter advances once per phase pulse over 2560 cycles.
// (R05) PWM is blocked from drivers until the first soft-start pulse.
// (R06) First switching cycle holds low-side on to charge bootstrap.
// (R07) Pre-charge above target below 113% withholds switching until reached.
// (R08) Enable low, pre-charge 113..120%: low-side on at 113%, off at 87%.
// (R09) Pre-charge above 120% latches the device off.
// (R10) Power-good stays low until soft-start completes.
// (R11) Power-good drops on disable or window fault held three cycles.
// (R12) Undervoltage armed after soft-start; below -13% drops power-good.
// (R13) Overvoltage above 120% latches high-side off; low-side off below 87%.
// (R14) Overvoltage latch holds enable and power-good low until bias cycles.
// (R15) Enable low and output above 113% turns low-side on until 87%.
// (R16) Over-temperature pulls shared enable low until the flag clears.
// (R17) Per-phase overcurrent must persist 7 cycles before being declared.
// (R18) Share bus above 1.2V reference also declares overcurrent.
// (R19) Declared overcurrent pulls enable low and turns both drives off.
// (R20) After overcurrent wait three soft-start intervals then retry.
// (R21) Trip during retry pulls enable low, interval expires, delay repeats.
// (R22) Shared wired-OR enable: any fault pulls low, low disables all. Code pulls only on overcurrent, OV/pre-charge latch and over-temperature.
// (R23) Sync missing 13 cycles disables until relock, then fresh soft-start.
// (R24) Analog comparator flags are synchronised before use.
`default_nettype none
package seq_pkg;
    // ------------------------------------------------------------------
    // Timing counts, in switching (phase) clock cycles, and counter widths.
    // ------------------------------------------------------------------
    localparam int unsigned START_DELAY_CYC = 384;
    localparam int unsigned SS_RAMP_CYC     = 2560;
    localparam int unsigned HICCUP_SS_MULT  = 3;
    localparam int unsigned PG_FILT_CYC     = 3;
    localparam int unsigned OC_FILT_CYC     = 7;
    localparam int unsigned SYNC_LOSS_CYC   = 13;
    localparam int unsigned CNT_W           = 14;
    localparam int unsigned FILT_W          = 4;

    // Sequencer states, one-hot.
    typedef enum logic [6:0] {
        ST_OFF    = 7'b000_0001,
        ST_DELAY  = 7'b000_0010,
        ST_SOFT   = 7'b000_0100,
        ST_RUN    = 7'b000_1000,
        ST_HICCUP = 7'b001_0000,
        ST_OVLAT  = 7'b010_0000,
        ST_PRELAT = 7'b100_0000
    } seq_state_t;
endpackage
`default_nettype wire

// [rtl/flag_if.sv]
// Interface carrying synchronised comparator flags between modules.
`default_nettype none
interface flag_if #(parameter int unsigned N = 12);
    logic [N-1:0] raw;
    logic [N-1:0] sync;
    modport src (output raw, input sync);
    modport syn (input raw, output sync);
endinterface
`default_nettype wire

// [rtl/flag_sync.sv]
// Two-stage synchroniser for asynchronous comparator flags.
`default_nettype none
module flag_sync #(
    parameter int unsigned N = 12
) (
    // Clock and reset.
    input  wire logic mclk_i,
    input  wire logic sys_rst_i,
    // Flag bundle.
    flag_if.syn       flags
);
    logic [N-1:0] meta_ff;
    logic [N-1:0] sync_ff;

    // Second stage alone reads the first stage (see R24).
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= flags.raw;
            sync_ff <= meta_ff;
        end
    end

    assign flags.sync = sync_ff;
endmodule
`default_nettype wire

// [rtl/regulator_startup_fault_sequencer.sv]
// Start-up, soft-start and fault sequencer of a switching regulator.
`default_nettype none
module regulator_startup_fault_sequencer
    import seq_pkg::*;
#(
    parameter int unsigned START_DELAY = START_DELAY_CYC,
    parameter int unsigned SS_CYCLES   = SS_RAMP_CYC,
    parameter int unsigned SYNC_LOSS   = SYNC_LOSS_CYC
) (
    // Clock and reset.
    input  wire logic             mclk_i,
    input  wire logic             sys_rst_i,
    // Asynchronous status and comparator flags.
    input  wire logic             en_above_thr_i,
    input  wire logic             bias_ok_i,
    input  wire logic             pll_lock_i,
    input  wire logic             sync_clock_input_i,
    input  wire logic             out_above_target_i,
    input  wire logic             out_above_113_i,
    input  wire logic             out_above_120_i,
    input  wire logic             out_below_87_i,
    input  wire logic             out_below_uv_i,
    input  wire logic             out_window_ok_i,
    input  wire logic             over_temp_i,
    input  wire logic             phase_oc_i,
    input  wire logic             share_bus_oc_i,
    // Loop-side inputs on the switching clock.
    input  wire logic             pwm_i,
    input  wire logic             ref_reached_out_i,
    // Shared enable line (open drain) and drives.
    output logic                  en_pull_low_oe_o,
    output logic                  en_pull_low_o,
    output logic                  hyst_sink_en_o,
    output logic                  high_side_drive_o,
    output logic                  low_side_drive_o,
    output logic                  power_good_flag_o,
    output logic [CNT_W-1:0]      ss_ref_o,
    output logic                  overvoltage_protect_o,
    output logic                  overcurrent_protect_o,
    output logic                  undervoltage_indication_o
);
    // ------------------------------------------------------------------
    // Flag synchronisation.
    // ------------------------------------------------------------------
    localparam int unsigned NFLAG = 14;
    flag_if #(.N(NFLAG)) flags ();
    assign flags.raw = {sync_clock_input_i, en_above_thr_i, bias_ok_i,
                        pll_lock_i, out_above_target_i, out_above_113_i,
                        out_above_120_i, out_below_87_i, out_below_uv_i,
                        out_window_ok_i, over_temp_i, phase_oc_i,
                        share_bus_oc_i, 1'b0};

    flag_sync #(.N(NFLAG)) u_sync (
        .mclk_i    (mclk_i),
        .sys_rst_i (sys_rst_i),
        .flags     (flags)
    );

    logic s_sync, s_en, s_bias, s_lock, s_tgt, s_113, s_120, s_87, s_uv;
    logic s_win, s_ot, s_poc, s_soc, s_unused;
    assign {s_sync, s_en, s_bias, s_lock, s_tgt, s_113, s_120, s_87, s_uv,
            s_win, s_ot, s_poc, s_soc, s_unused} = flags.sync;

    // ------------------------------------------------------------------
    // Registers.
    // ------------------------------------------------------------------
    seq_state_t        state_ff, nxt_state;
    logic [CNT_W-1:0]  cnt_ff;
    logic [1:0]        hic_ff;
    logic [FILT_W-1:0] oc_cnt_ff;
    logic [FILT_W-1:0] pg_cnt_ff;
    logic [FILT_W-1:0] sync_cnt_ff;
    logic              sync_prev_ff;
    logic              sync_lost_ff;
    logic              first_pulse_ff;
    logic              boot_ff;
    logic              wait_ref_ff;
    logic              ls_clamp_ff;
    logic              ot_hold_ff;
    logic              ls_ov_ff;
    logic              oc_evt;
    logic              ready;
    logic              line_low;

    // Shared line is seen low when our own pull or a sibling holds it low.
    assign line_low = !s_en || en_pull_low_oe_o;
    // Start qualification (see R01) (see R23).
    assign ready    = s_en && s_bias && s_lock && !sync_lost_ff;
    // Declared overcurrent from either path (see R17) (see R18).
    assign oc_evt   = (oc_cnt_ff >= FILT_W'(OC_FILT_CYC)) || s_soc;

    // ------------------------------------------------------------------
    // Per-phase overcurrent persistence filter.
    // ------------------------------------------------------------------
    // Saturating count of consecutive tripped cycles (see R17).
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i || !s_poc) begin
            oc_cnt_ff <= '0;
        end else if (oc_cnt_ff < FILT_W'(OC_FILT_CYC)) begin
            oc_cnt_ff <= oc_cnt_ff + FILT_W'(1);
        end
    end

    // ------------------------------------------------------------------
    // Sync clock loss watchdog.
    // ------------------------------------------------------------------
    // Any edge on the synchronised sync input restarts the count; a
    // static line for 13 cycles disables until the loop relocks.
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            sync_prev_ff <= 1'b0;
            sync_cnt_ff  <= '0;
            sync_lost_ff <= 1'b0;
        end else begin
            sync_prev_ff <= s_sync;
            if (s_sync != sync_prev_ff) begin
                sync_cnt_ff <= '0;
            end else if (sync_cnt_ff < FILT_W'(SYNC_LOSS)) begin
                sync_cnt_ff <= sync_cnt_ff + FILT_W'(1);
            end
            if (sync_cnt_ff >= FILT_W'(SYNC_LOSS) - FILT_W'(1)) begin
                sync_lost_ff <= 1'b1; // see R23
            end else if (!s_lock) begin
                sync_lost_ff <= sync_lost_ff;
            end else if (s_sync != sync_prev_ff) begin
                sync_lost_ff <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Next-state logic.
    // ------------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_OFF: begin
                if (s_120 && !s_bias) begin
                    nxt_state = ST_OFF;
                end else if (s_120) begin
                    nxt_state = ST_PRELAT; // see R09
                end else if (ready && !line_low) begin
                    nxt_state = ST_DELAY;
                end
            end
            ST_DELAY: begin
                if (!ready || line_low) begin
                    nxt_state = ST_OFF;
                end else if (cnt_ff == CNT_W'(START_DELAY - 1)) begin
                    nxt_state = ST_SOFT; // see R01
                end
            end
            ST_SOFT: begin
                if (s_120) begin
                    nxt_state = ST_OVLAT; // see R13
                end else if (oc_evt) begin
                    nxt_state = ST_HICCUP; // see R19
                end else if (!ready || line_low) begin
                    nxt_state = ST_OFF; // see R03 (see R22)
                end else if (cnt_ff == CNT_W'(SS_CYCLES - 1)) begin
                    nxt_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (s_120) begin
                    nxt_state = ST_OVLAT;
                end else if (oc_evt) begin
                    nxt_state = ST_HICCUP;
                end else if (!ready || line_low) begin
                    nxt_state = ST_OFF;
                end
            end
            ST_HICCUP: begin
                // Interval expires, then three soft-start delays (see R20).
                if (hic_ff == 2'(HICCUP_SS_MULT) &&
                    cnt_ff == CNT_W'(SS_CYCLES - 1)) begin
                    nxt_state = ST_DELAY; // see R21
                end
            end
            ST_OVLAT:  nxt_state = ST_OVLAT;  // see R14
            ST_PRELAT: nxt_state = ST_PRELAT;
            default:   nxt_state = ST_OFF;
        endcase
        // Only a bias supply cycle clears the latches (see R14).
        if (!s_bias && state_ff != ST_HICCUP) begin
            nxt_state = ST_OFF;
        end
    end

    // ------------------------------------------------------------------
    // State, interval counter and hiccup interval count.
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            state_ff <= ST_OFF;
            cnt_ff   <= '0;
            hic_ff   <= '0;
        end else begin
            state_ff <= nxt_state;
            if (nxt_state != state_ff) begin
                cnt_ff <= '0; // see R03
                hic_ff <= '0;
            end else if (state_ff == ST_HICCUP &&
                         cnt_ff == CNT_W'(SS_CYCLES - 1)) begin
                cnt_ff <= '0;
                hic_ff <= hic_ff + 2'd1;
            end else begin
                cnt_ff <= cnt_ff + CNT_W'(1); // see R04
            end
        end
    end

    // ------------------------------------------------------------------
    // Pre-charge handling, first pulse and bootstrap cycle.
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i || state_ff != ST_SOFT && state_ff != ST_RUN) begin
            first_pulse_ff <= 1'b0;
            boot_ff        <= 1'b0;
            wait_ref_ff    <= 1'b0;
        end else begin
            // Output already above target: hold off until ramp catches up.
            if (state_ff == ST_SOFT && cnt_ff == '0) begin
                wait_ref_ff <= s_tgt && !s_113; // see R07
            end else if (ref_reached_out_i) begin
                wait_ref_ff <= 1'b0;
            end
            if (pwm_i && !wait_ref_ff && !first_pulse_ff) begin
                first_pulse_ff <= 1'b1; // see R05
                boot_ff        <= 1'b1; // see R06
            end else begin
                boot_ff        <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Non-latched low-side clamp with enable low, and OV latch clamp.
    // ------------------------------------------------------------------
    // Hysteresis 113%/87% protects siblings sharing the load.
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            ls_clamp_ff <= 1'b0;
            ls_ov_ff    <= 1'b0;
        end else begin
            if (line_low && s_113) begin
                ls_clamp_ff <= 1'b1; // see R08 (see R15)
            end else if (s_87 || !line_low) begin
                ls_clamp_ff <= 1'b0;
            end
            if (state_ff != ST_OVLAT && nxt_state == ST_OVLAT) begin
                ls_ov_ff <= 1'b1; // see R13
            end else if (s_87 || state_ff != ST_OVLAT) begin
                ls_ov_ff <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Over-temperature hold of the shared line.
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            ot_hold_ff <= 1'b0;
        end else begin
            ot_hold_ff <= s_ot; // see R16
        end
    end

    // ------------------------------------------------------------------
    // Power-good window filter.
    // ------------------------------------------------------------------
    // Counts consecutive window or undervoltage faults once running.
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i || state_ff != ST_RUN) begin
            pg_cnt_ff <= '0;
        end else if (!s_win || s_uv) begin
            if (pg_cnt_ff < FILT_W'(PG_FILT_CYC)) begin
                pg_cnt_ff <= pg_cnt_ff + FILT_W'(1); // see R11 (see R12)
            end
        end else begin
            pg_cnt_ff <= '0;
        end
    end

    // ------------------------------------------------------------------
    // Registered outputs.
    // ------------------------------------------------------------------
    // Gates are decided from the next state so a fault changes them on
    // the very next edge, well under 100 ns at this clock.
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            en_pull_low_oe_o          <= 1'b0;
            en_pull_low_o             <= 1'b0;
            hyst_sink_en_o            <= 1'b1;
            high_side_drive_o         <= 1'b0;
            low_side_drive_o          <= 1'b0;
            power_good_flag_o         <= 1'b0;
            ss_ref_o                  <= '0;
            overvoltage_protect_o     <= 1'b0;
            overcurrent_protect_o     <= 1'b0;
            undervoltage_indication_o <= 1'b0;
        end else begin
            // Pull the shared line on overcurrent, overvoltage, pre-charge latch or over-temperature (see R22).
            en_pull_low_oe_o <= nxt_state == ST_HICCUP ||
                                nxt_state == ST_OVLAT ||
                                nxt_state == ST_PRELAT || s_ot || ot_hold_ff;
            en_pull_low_o    <= 1'b0;
            // Sink on while not enabled (see R02).
            hyst_sink_en_o   <= !(nxt_state == ST_SOFT ||
                                  nxt_state == ST_RUN);
            if (nxt_state == ST_SOFT || nxt_state == ST_RUN) begin
                high_side_drive_o <= first_pulse_ff && !boot_ff &&
                                     !wait_ref_ff && pwm_i; // see R05
                low_side_drive_o  <= boot_ff || (first_pulse_ff &&
                                     !wait_ref_ff && !pwm_i); // see R06
            end else begin
                high_side_drive_o <= 1'b0; // see R03 (see R19)
                low_side_drive_o  <= ls_clamp_ff || ls_ov_ff;
            end
            ss_ref_o <= (state_ff == ST_SOFT) ? cnt_ff :
                        (state_ff == ST_RUN) ? CNT_W'(SS_CYCLES) : '0;
            // Power-good only after soft-start (see R10).
            power_good_flag_o <= nxt_state == ST_RUN && state_ff == ST_RUN
                                 && pg_cnt_ff < FILT_W'(PG_FILT_CYC)
                                 || (state_ff == ST_SOFT &&
                                     nxt_state == ST_RUN);
            overvoltage_protect_o <= nxt_state == ST_OVLAT ||
                                     nxt_state == ST_PRELAT;
            overcurrent_protect_o <= nxt_state == ST_HICCUP;
            undervoltage_indication_o <= state_ff == ST_RUN && s_uv;
        end
    end
endmodule
`default_nettype wire

// [bench/enable_line_model.sv]
// Model of the shared wired-OR enable line, the device and its siblings.
`default_nettype none
module enable_line_model (
    // Open-drain pulls onto the shared line.
    input  wire logic dut_pull_i,
    input  wire logic sib_pull_i,
    // Level seen by every party.
    output logic      line_high_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // The pull-up wins only while nobody pulls, so one fault stops all.
    assign line_high_o = !(dut_pull_i || sib_pull_i);
endmodule
`default_nettype wire

// [bench/seq_asserts.sv]
// Concurrent checks on the sequencer's ports, bound into the design.
`default_nettype none
module seq_asserts
    import seq_pkg::*;
(
    // Clock, reset and watched inputs.
    input wire logic             mclk_i,
    input wire logic             sys_rst_i,
    input wire logic             en_above_thr_i,
    input wire logic             out_window_ok_i,
    input wire logic             over_temp_i,
    input wire logic             phase_oc_i,
    input wire logic             share_bus_oc_i,
    // Watched outputs.
    input wire logic             en_pull_low_oe_o,
    input wire logic             hyst_sink_en_o,
    input wire logic             high_side_drive_o,
    input wire logic             low_side_drive_o,
    input wire logic             power_good_flag_o,
    input wire logic [CNT_W-1:0] ss_ref_o,
    input wire logic             overvoltage_protect_o,
    input wire logic             overcurrent_protect_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (sys_rst_i);
    // A short blip on the phase comparator, then quiet.
    sequence s_oc_blip;
        !phase_oc_i ##1 phase_oc_i [*3] ##1 !phase_oc_i [*8];
    endsequence
    property p_rst_val;
        $fell(sys_rst_i) |-> !high_side_drive_o && !low_side_drive_o
            && !en_pull_low_oe_o && hyst_sink_en_o && !power_good_flag_o
            && ss_ref_o == '0;
    endproperty
    property p_no_overlap;
        !(high_side_drive_o && low_side_drive_o);
    endproperty
    property p_pg_sink;
        power_good_flag_o |-> !hyst_sink_en_o;
    endproperty
    property p_win;
        !out_window_ok_i [*7] |-> !power_good_flag_o;
    endproperty
    property p_ot;
        over_temp_i [*4] |-> en_pull_low_oe_o;
    endproperty
    property p_oc_off;
        $rose(overcurrent_protect_o) |-> ##[0:1] (en_pull_low_oe_o
            && !high_side_drive_o && !low_side_drive_o);
    endproperty
    property p_oc_filt;
        !overcurrent_protect_o ##0 (!share_bus_oc_i throughout s_oc_blip)
            |-> !overcurrent_protect_o;
    endproperty
    property p_share;
        $rose(share_bus_oc_i) && ss_ref_o != '0 && !overcurrent_protect_o
            |-> ##[1:6] overcurrent_protect_o;
    endproperty
    property p_ov;
        overvoltage_protect_o |-> en_pull_low_oe_o && !power_good_flag_o
            && !high_side_drive_o;
    endproperty
    property p_line;
        !en_above_thr_i [*4] |-> !high_side_drive_o && !power_good_flag_o;
    endproperty
    // ------------------------------------------------------------------
    // Assertions.
    // ------------------------------------------------------------------
    a_rst_val: assert property (p_rst_val) else $error("bad reset state");
    a_no_overlap: assert property (p_no_overlap) else $error("both drives on");
    a_pg_sink: assert property (p_pg_sink) else $error("sink on at good");
    a_win: assert property (p_win) else $error("good kept on fault");
    a_ot: assert property (p_ot) else $error("hot, line free");
    a_oc_off: assert property (p_oc_off) else $error("drive after trip");
    a_oc_filt: assert property (p_oc_filt) else $error("blip tripped");
    a_share: assert property (p_share) else $error("share trip missed");
    a_ov: assert property (p_ov) else $error("latch not holding");
    a_line: assert property (p_line) else $error("ran on low line");
endmodule
bind regulator_startup_fault_sequencer seq_asserts i_seq_asserts (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .en_above_thr_i(en_above_thr_i),
    .out_window_ok_i(out_window_ok_i), .over_temp_i(over_temp_i),
    .phase_oc_i(phase_oc_i), .share_bus_oc_i(share_bus_oc_i),
    .en_pull_low_oe_o(en_pull_low_oe_o), .hyst_sink_en_o(hyst_sink_en_o),
    .high_side_drive_o(high_side_drive_o),
    .low_side_drive_o(low_side_drive_o),
    .power_good_flag_o(power_good_flag_o), .ss_ref_o(ss_ref_o),
    .overvoltage_protect_o(overvoltage_protect_o),
    .overcurrent_protect_o(overcurrent_protect_o)
);
`default_nettype wire

// [bench/test_regulator_startup_fault_sequencer.sv]
// Self-checking bench for the start-up and fault sequencer.
`default_nettype none
module test_regulator_startup_fault_sequencer
    import seq_pkg::*;
();
    timeunit 1ns;
    timeprecision 100ps;
    // Short ramp keeps each hiccup round brief.
    localparam int unsigned SS = 20;
    localparam int unsigned SD = START_DELAY_CYC;
    logic             mclk_i = 1'b0;
    logic             sys_rst_i, bias_ok, pll_lock, sync_in, run_clk, pwm_on;
    logic             above_113, above_120, below_87, win_ok, over_temp;
    logic             phase_oc, share_oc, pwm, sib_pull, line_high, seen;
    logic             pull_oe, sink_en, hs, ls, pg, overvoltage_protect, overcurrent_protect, uv, uvi;
    logic [CNT_W-1:0] ss_ref, r0;
    int               fail_count = 0;
    int               cmp_count = 0;
    regulator_startup_fault_sequencer #(.SS_CYCLES(SS))
    i_regulator_startup_fault_sequencer (
        .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .en_above_thr_i(line_high),
        .bias_ok_i(bias_ok), .pll_lock_i(pll_lock),
        .sync_clock_input_i(sync_in), .out_above_target_i(1'b0),
        .out_above_113_i(above_113), .out_above_120_i(above_120),
        .out_below_87_i(below_87), .out_below_uv_i(uv),
        .out_window_ok_i(win_ok), .over_temp_i(over_temp),
        .phase_oc_i(phase_oc), .share_bus_oc_i(share_oc), .pwm_i(pwm),
        .ref_reached_out_i(1'b1), .en_pull_low_oe_o(pull_oe),
        .en_pull_low_o(), .hyst_sink_en_o(sink_en),
        .high_side_drive_o(hs), .low_side_drive_o(ls),
        .power_good_flag_o(pg), .ss_ref_o(ss_ref),
        .overvoltage_protect_o(overvoltage_protect), .overcurrent_protect_o(overcurrent_protect),
        .undervoltage_indication_o(uvi)
    );
    enable_line_model i_enable_line_model (
        .dut_pull_i(pull_oe), .sib_pull_i(sib_pull), .line_high_o(line_high)
    );
    // ------------------------------------------------------------------
    // Clock, sync toggling and shared tasks.
    // ------------------------------------------------------------------
    initial forever #2.5 mclk_i = ~mclk_i;
    // The sync input only moves while running, so its loss can be staged.
    always @(posedge mclk_i) begin
        #1;
        sync_in = run_clk ? ~sync_in : 1'b0;
        pwm = pwm_on ? ~pwm : 1'b0;
    end
    task cyc(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask
    task chk(input logic [15:0] s, input logic [15:0] e);
        cmp_count++;
        if (s !== e) begin
            fail_count++;
            $display("unexpected at %0t: %h vs %h", $time, s, e);
        end
    endtask
    // Bounded wait for the ramp to leave zero.
    task wait_ss(input int lim);
        for (int i = 0; i < lim && ss_ref === '0; i++) cyc(1);
    endtask
    task complete_run;
        if (fail_count == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        cyc(20000);
        fail_count++;
        complete_run;
    end
    // ------------------------------------------------------------------
    // Main sequence.
    // ------------------------------------------------------------------
    initial begin
        {sys_rst_i, bias_ok, pll_lock, run_clk, pwm_on} = 5'h10;
        {above_113, above_120, below_87, win_ok, over_temp} = 5'h06;
        {phase_oc, share_oc, sib_pull, uv} = 4'h0;
        cyc(6);
        chk({hs, ls, pg, pull_oe, sink_en}, 5'h01);
        chk(ss_ref, 16'h0000);
        sys_rst_i = 1'b0;
        {bias_ok, pll_lock, run_clk} = 3'h7;
        cyc(SD - 8);
        chk({ss_ref != 0, hs}, 2'h0);
        wait_ss(40);
        r0 = ss_ref;
        cyc(3);
        chk({ss_ref != 0, hs, pg}, 3'h4);
        chk(ss_ref - r0, 16'h0003);
        pwm_on = 1'b1;
        seen = 1'b0;
        repeat (4) begin
            cyc(1);
            seen = seen | ls;
        end
        chk(seen, 1'h1);
        cyc(SS + 10);
        chk({pg, sink_en}, 2'h2);
        win_ok = 1'b0;
        cyc(2);
        win_ok = 1'b1;
        cyc(8);
        chk(pg, 1'h1);
        win_ok = 1'b0;
        cyc(10);
        chk(pg, 1'h0);
        win_ok = 1'b1;
        phase_oc = 1'b1;
        cyc(3);
        phase_oc = 1'b0;
        cyc(8);
        chk(overcurrent_protect, 1'h0);
        phase_oc = 1'b1;
        cyc(12);
        phase_oc = 1'b0;
        chk({overcurrent_protect, pull_oe, hs, ls}, 4'hc);
        cyc(4 * SS + SD - 20);
        chk({ss_ref != 0, pg}, 2'h0);
        wait_ss(60);
        chk(ss_ref != 0, 1'h1);
        share_oc = 1'b1;
        cyc(6);
        share_oc = 1'b0;
        chk({overcurrent_protect, pg}, 2'h2);
        cyc(4 * SS + SD - 20);
        wait_ss(60);
        cyc(SS + 10);
        chk(pg, 1'h1);
        uv = 1'b1;
        cyc(7);
        chk({uvi, pg}, 2'h2);
        {uv, run_clk} = 2'h0;
        cyc(24);
        chk({hs, pg}, 2'h0);
        run_clk = 1'b1;
        cyc(SD);
        wait_ss(60);
        chk(ss_ref != 0, 1'h1);
        over_temp = 1'b1;
        cyc(6);
        chk({pull_oe, hs, pg}, 3'h4);
        over_temp = 1'b0;
        cyc(6);
        chk(pull_oe, 1'h0);
        sib_pull = 1'b1;
        cyc(6);
        chk({hs, pg}, 2'h0);
        {above_113, below_87} = 2'h2;
        cyc(6);
        chk(ls, 1'h1);
        {above_113, below_87} = 2'h1;
        cyc(6);
        chk({ls, overvoltage_protect}, 2'h0);
        sib_pull = 1'b0;
        cyc(SD);
        wait_ss(60);
        {above_113, above_120, below_87} = 3'h6;
        cyc(6);
        chk({overvoltage_protect, pull_oe, hs, ls, pg}, 5'h1a);
        {above_113, above_120, below_87} = 3'h1;
        cyc(6);
        chk({overvoltage_protect, ls}, 2'h2);
        bias_ok = 1'b0;
        cyc(4);
        chk(overvoltage_protect, 1'h0);
        {bias_ok, above_120} = 2'h3;
        cyc(4);
        chk({overvoltage_protect, pull_oe}, 2'h3);
        complete_run;
    end
endmodule
`default_nettype wire
